// ---- rtl/aos_core.sv ----
`timescale 1ns/1ps
`include "aos_regs.svh"
module aos_core
  import aos_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Sensor side
  input wire aos_pkg::aos_sample_t sample,
  input wire logic sample_valid,
  output logic self_test_en,
  output logic [3:0] rate_code,
  output logic low_power
);
  import aos_pkg::*;

  logic [7:0] ofs [3];
  logic [7:0] rate;
  logic [7:0] fmt;
  logic [15:0] data [3];
  logic [2:0] settle;
  logic st_prev;

  // Bus decode
  wire logic [9:0] idx = paddr[11:2];
  wire logic setup = psel && !penable;
  wire logic acc = psel && penable;
  wire logic wr = acc && pwrite;
  wire logic mapped = (idx >= 10'(`AOS_IDX_OFS_X) && idx <= 10'(`AOS_IDX_OFS_Z))
    || idx == 10'(`AOS_IDX_RATE) || idx == 10'(`AOS_IDX_FMT)
    || idx == 10'(`AOS_IDX_STAT)
    || (idx >= 10'(`AOS_IDX_DATA_X) && idx <= 10'(`AOS_IDX_DATA_Z));
  wire logic full_res = fmt[`AOS_FMT_FULL_RES];
  wire logic [1:0] range_sel = fmt[1:0];

  // Trim scaled to output counts
  function automatic logic [15:0] trim_counts(input logic [7:0] t, input logic fr,
                                              input logic [1:0] rg);
    logic [15:0] se;
    se = {{8{t[7]}}, t};
    if (fr) begin
      trim_counts = 16'(se << `AOS_OFS_SHIFT_FULL);
    end else begin
      trim_counts = 16'($signed(se <<< `AOS_OFS_SHIFT_FULL) >>> rg);
    end
  endfunction

  // Read mux
  logic [31:0] next_prdata;
  always_comb begin
    next_prdata = 32'h0;
    if (idx >= 10'(`AOS_IDX_OFS_X) && idx <= 10'(`AOS_IDX_OFS_Z)) begin
      next_prdata = {24'h0, ofs[2'(idx - 10'(`AOS_IDX_OFS_X))]};
    end else if (idx == 10'(`AOS_IDX_RATE)) begin
      next_prdata = {24'h0, rate};
    end else if (idx == 10'(`AOS_IDX_FMT)) begin
      next_prdata = {24'h0, fmt};
    end else if (idx == 10'(`AOS_IDX_STAT)) begin
      next_prdata = {29'h0, settle};
    end else if (idx >= 10'(`AOS_IDX_DATA_X) && idx <= 10'(`AOS_IDX_DATA_Z)) begin
      next_prdata = {16'h0, data[2'(idx - 10'(`AOS_IDX_DATA_X))]};
    end
  end

  // APB answer, no wait states
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end else begin
      pready <= setup;
      pslverr <= setup && !mapped;
      prdata <= setup ? next_prdata : 32'h0;
    end
  end

  // Control registers
  wire logic wdone = wr && pready;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rate <= `AOS_RATE_RST;
      fmt <= `AOS_FMT_RST;
    end else begin
      if (wdone && idx == 10'(`AOS_IDX_RATE)) rate <= pwdata[7:0];
      if (wdone && idx == 10'(`AOS_IDX_FMT)) fmt <= pwdata[7:0];
    end
  end

  // Per-axis trims and corrected data
  genvar a;
  generate
    for (a = 0; a < 3; a++) begin : g_axis
      wire logic [12:0] raw = (a == 0) ? sample.x : (a == 1) ? sample.y : sample.z;
      wire logic [15:0] sum = 16'({{3{raw[12]}}, raw} + trim_counts(ofs[a], full_res,
                                                                   range_sel));
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          ofs[a] <= `AOS_OFS_RST;
          data[a] <= 16'h0;
        end else begin
          if (wdone && idx == 10'(`AOS_IDX_OFS_X) + 10'(a)) ofs[a] <= pwdata[7:0];
          if (sample_valid) data[a] <= sum;
        end
      end
    end
  endgenerate

  // Self-test drive and settle counter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      self_test_en <= 1'b0;
      st_prev <= 1'b0;
      settle <= 3'h0;
      rate_code <= 4'h0;
      low_power <= 1'b0;
    end else begin
      self_test_en <= fmt[`AOS_FMT_SELF_TEST];
      st_prev <= fmt[`AOS_FMT_SELF_TEST];
      rate_code <= rate[3:0];
      low_power <= rate[`AOS_RATE_LOW_POWER];
      if (fmt[`AOS_FMT_SELF_TEST] != st_prev) begin
        settle <= `AOS_ST_SETTLE;
      end else if (sample_valid && settle != 3'h0) begin
        settle <= settle - 3'h1;
      end
    end
  end

  // Full-res expected sums, built apart from the datapath
  wire logic [15:0] exp_x = {{3{sample.x[12]}}, sample.x} + {{6{ofs[0][7]}}, ofs[0], 2'b00};
  wire logic [15:0] exp_y = {{3{sample.y[12]}}, sample.y} + {{6{ofs[1][7]}}, ofs[1], 2'b00};
  wire logic [15:0] exp_z = {{3{sample.z[12]}}, sample.z} + {{6{ofs[2][7]}}, ofs[2], 2'b00};

  // Trims zero once reset lifts
  property p_trim_reset;
    @(posedge pclk) $rose(presetn) |-> ofs[0] == 8'h00 && ofs[1] == 8'h00 && ofs[2] == 8'h00;
  endproperty
  a_trim_reset: assert property (p_trim_reset) else $error("trim not zero after reset");

  // Full-res X data is sample plus four counts per trim step
  property p_data_sum;
    @(posedge pclk) disable iff (!presetn)
      sample_valid && full_res |=> data[0] == $past(exp_x);
  endproperty
  a_data_sum: assert property (p_data_sum) else $error("x data not trim plus sample");

  // Full-res trim scale is four counts per step
  property p_scale_full;
    @(posedge pclk) disable iff (!presetn)
      full_res |-> trim_counts(ofs[1], 1'b1, range_sel) == {{6{ofs[1][7]}}, ofs[1], 2'b00};
  endproperty
  a_scale_full: assert property (p_scale_full) else $error("full res scale not four");

  // Negative trims stay negative
  property p_sign_ext;
    @(posedge pclk) disable iff (!presetn)
      ofs[2][7] |-> trim_counts(ofs[2], full_res, range_sel)[15];
  endproperty
  a_sign_ext: assert property (p_sign_ext) else $error("trim sign lost");

  // Full-res Y correction ignores the range field
  property p_range_free;
    @(posedge pclk) disable iff (!presetn)
      sample_valid && full_res |=> data[1] == $past(exp_y);
  endproperty
  a_range_free: assert property (p_range_free) else $error("trim depends on range");

  // Z data is sample plus scaled trim
  property p_data_z;
    @(posedge pclk) disable iff (!presetn)
      sample_valid && full_res |=> data[2] == $past(exp_z);
  endproperty
  a_data_z: assert property (p_data_z) else $error("z data not trim plus sample");

  // Data holds between samples
  property p_data_hold;
    @(posedge pclk) disable iff (!presetn)
      !sample_valid |=> $stable(data[0]);
  endproperty
  a_data_hold: assert property (p_data_hold) else $error("x data moved without sample");

  // Trim write lands
  property p_ofs_write;
    @(posedge pclk) disable iff (!presetn)
      wdone && idx == 10'(`AOS_IDX_OFS_Y) |=> ofs[1] == $past(pwdata[7:0]);
  endproperty
  a_ofs_write: assert property (p_ofs_write) else $error("trim write lost");

  // Trim holds without a write
  property p_ofs_keep;
    @(posedge pclk) disable iff (!presetn)
      !wdone |=> $stable(ofs[0]);
  endproperty
  a_ofs_keep: assert property (p_ofs_keep) else $error("trim moved without write");

  // Ready is a single pulse
  property p_ready_pulse;
    @(posedge pclk) disable iff (!presetn)
      pready |=> !pready;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("ready longer than one cycle");

  // Ready follows every setup
  property p_ready_setup;
    @(posedge pclk) disable iff (!presetn)
      setup |=> pready;
  endproperty
  a_ready_setup: assert property (p_ready_setup) else $error("no ready after setup");

  // Unmapped access flags an error
  property p_err_map;
    @(posedge pclk) disable iff (!presetn)
      setup && !mapped |=> pslverr;
  endproperty
  a_err_map: assert property (p_err_map) else $error("unmapped access not refused");

  // Mapped access has no error
  property p_err_ok;
    @(posedge pclk) disable iff (!presetn)
      setup && mapped |=> !pslverr;
  endproperty
  a_err_ok: assert property (p_err_ok) else $error("mapped access refused");

  // Read data only with ready
  property p_rd_idle;
    @(posedge pclk) disable iff (!presetn)
      !pready |-> prdata == 32'h0;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside ready");

  // Rate code output tracks register
  property p_rate_out;
    @(posedge pclk) disable iff (!presetn)
      1'b1 |=> rate_code == $past(rate[3:0]);
  endproperty
  a_rate_out: assert property (p_rate_out) else $error("rate code output stale");

  // Power mode output tracks register
  property p_lp_out;
    @(posedge pclk) disable iff (!presetn)
      1'b1 |=> low_power == $past(rate[`AOS_RATE_LOW_POWER]);
  endproperty
  a_lp_out: assert property (p_lp_out) else $error("power mode output stale");

  // Settle count steps down per sample
  property p_settle_dec;
    @(posedge pclk) disable iff (!presetn)
      fmt[`AOS_FMT_SELF_TEST] == st_prev && sample_valid && settle != 3'h0
        |=> settle == $past(settle) - 3'h1;
  endproperty
  a_settle_dec: assert property (p_settle_dec) else $error("settle count not stepped");

  // Settle count holds without samples
  property p_settle_hold;
    @(posedge pclk) disable iff (!presetn)
      fmt[`AOS_FMT_SELF_TEST] == st_prev && !sample_valid |=> $stable(settle);
  endproperty
  a_settle_hold: assert property (p_settle_hold) else $error("settle count drifted");

  // Self-test output follows format bit
  property p_st_follow;
    @(posedge pclk) disable iff (!presetn)
      $changed(fmt[`AOS_FMT_SELF_TEST]) |=> self_test_en == $past(fmt[`AOS_FMT_SELF_TEST]);
  endproperty
  a_st_follow: assert property (p_st_follow) else $error("self-test not applied");

  // Settle count loaded on self-test change
  property p_settle;
    @(posedge pclk) disable iff (!presetn)
      $changed(fmt[`AOS_FMT_SELF_TEST]) |=> ##1 settle == 3'h4;
  endproperty
  a_settle: assert property (p_settle) else $error("settle count not loaded");

  // Format write lands
  property p_fmt_write;
    @(posedge pclk) disable iff (!presetn)
      wdone && idx == 10'(`AOS_IDX_FMT) |=> fmt == $past(pwdata[7:0]) ##1 1'b1;
  endproperty
  a_fmt_write: assert property (p_fmt_write) else $error("format write lost");
endmodule

// ---- rtl/aos_pkg.sv ----
package aos_pkg;
  // Measured sample for one axis set
  typedef struct packed {
    logic [12:0] x;
    logic [12:0] y;
    logic [12:0] z;
  } aos_sample_t;
  // APB request
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } aos_apb_req_t;
endpackage

// ---- rtl/aos_regs.svh ----
`ifndef AOS_REGS_SVH
`define AOS_REGS_SVH
// Register indices; the byte address on the bus is four times the index
`define AOS_IDX_OFS_X 8'h1e
`define AOS_IDX_OFS_Y 8'h1f
`define AOS_IDX_OFS_Z 8'h20
`define AOS_IDX_RATE 8'h2c
`define AOS_IDX_FMT 8'h31
`define AOS_IDX_CTRL 8'h3c
`define AOS_IDX_STAT 8'h3d
`define AOS_IDX_DATA_X 8'h40
`define AOS_IDX_DATA_Y 8'h41
`define AOS_IDX_DATA_Z 8'h42
// Reset values
`define AOS_OFS_RST 8'h00
`define AOS_RATE_RST 8'h0a
`define AOS_FMT_RST 8'h00
// Field positions
`define AOS_FMT_SELF_TEST 7
`define AOS_FMT_FULL_RES 3
`define AOS_RATE_LOW_POWER 4
// Offset step 15.6 mg, full-res count 3.9 mg: ratio four, two bit shift
`define AOS_OFS_SHIFT_FULL 2
// Settling samples after a self-test change
`define AOS_ST_SETTLE 3'h4
`endif

// ---- verif/aos_core_tb.sv ----
`timescale 1ns/1ps
`include "aos_regs.svh"
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin num_errors++; \
  $display("unexpected at %0t: got %h exp %h", $time, a, b); end end
module aos_core_tb;
  import aos_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic sample_valid = 1'b0;
  aos_sample_t sample = '0;
  wire psel, penable, pwrite, pready, pslverr, self_test_en, low_power;
  wire [11:0] paddr;
  wire [31:0] pwdata, prdata;
  wire [3:0] rate_code;
  logic [31:0] rd;
  logic err;
  int num_errors = 0;
  int n_compared = 0;
  int cycles = 0;
  aos_host u_host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  aos_core u_aos_core (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sample(sample), .sample_valid(sample_valid),
    .self_test_en(self_test_en), .rate_code(rate_code), .low_power(low_power));
  // Clock and hang guard
  always #12.5 pclk = ~pclk;
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 5000) begin
      num_errors++;
      test_done();
    end
  end
  task automatic test_done;
    $display("errors %0d compared %0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // Register read with expected word, register write
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    u_host.xfer(1'b0, a, 32'h0000_0000, rd, err);
    `CHK(rd, e)
    `CHK(err, 1'b0)
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    u_host.xfer(1'b1, a, {24'h000000, d}, rd, err);
  endtask
  // One raw sample pulse
  task automatic smp(input logic [12:0] x, input logic [12:0] y, input logic [12:0] z);
    @(posedge pclk);
    sample <= {x, y, z};
    sample_valid <= 1'b1;
    @(posedge pclk);
    sample_valid <= 1'b0;
  endtask
  // Main sequence
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 3; i++) rchk(8'h1e + 8'(i), 32'h0000_0000);
    rchk(`AOS_IDX_RATE, 32'h0000_000a);
    rchk(`AOS_IDX_FMT, 32'h0000_0000);
    wr(`AOS_IDX_RATE, 8'h1d);
    repeat (2) @(posedge pclk);
    `CHK({low_power, rate_code}, 5'h1d)
    wr(`AOS_IDX_RATE, 8'h0a);
    repeat (2) @(posedge pclk);
    `CHK({low_power, rate_code}, 5'h0a)
    wr(`AOS_IDX_OFS_X, 8'hfd);
    wr(`AOS_IDX_OFS_Y, 8'h03);
    wr(`AOS_IDX_OFS_Z, 8'hfe);
    // Same full-res correction in every range
    for (int r = 0; r < 4; r++) begin
      wr(`AOS_IDX_FMT, 8'h08 | 8'(r));
      smp(13'h000a, 13'h1ff3, 13'h0009);
      rchk(`AOS_IDX_DATA_X, 32'h0000_fffe);
      rchk(`AOS_IDX_DATA_Y, 32'h0000_ffff);
      rchk(`AOS_IDX_DATA_Z, 32'h0000_0001);
    end
    // Self-test on, settle count, off
    wr(`AOS_IDX_FMT, 8'h8b);
    repeat (2) @(posedge pclk);
    `CHK(self_test_en, 1'b1)
    rchk(`AOS_IDX_STAT, 32'h0000_0004);
    smp(13'h0000, 13'h0000, 13'h0000);
    rchk(`AOS_IDX_STAT, 32'h0000_0003);
    smp(13'h0000, 13'h0000, 13'h0020);
    rchk(`AOS_IDX_DATA_Z, 32'h0000_0018);
    wr(`AOS_IDX_FMT, 8'h0b);
    repeat (2) @(posedge pclk);
    `CHK(self_test_en, 1'b0)
    smp(13'h0000, 13'h0000, 13'h0000);
    rchk(`AOS_IDX_DATA_Z, 32'h0000_fff8);
    // Unmapped place refuses
    u_host.xfer(1'b1, 8'h3c, 32'h0000_00ff, rd, err);
    `CHK(err, 1'b1)
    u_host.xfer(1'b0, 8'h3c, 32'h0000_0000, rd, err);
    `CHK({err, rd}, {1'b1, 32'h0000_0000})
    test_done();
  end
endmodule

// ---- verif/aos_host.sv ----
`timescale 1ns/1ps
module aos_host (
  // Clock
  input wire logic pclk,
  // APB master side
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  // Idle bus at time zero
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
  end
  // One transfer: setup, then access held until pready; psel and penable drop, paddr and pwdata show inverted values
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic err);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {2'b00, a, 2'b00};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~{2'b00, a, 2'b00};
    pwdata <= ~d;
  endtask
endmodule
